// file: sarh_pkg.sv
package sarh_pkg;
	// Clock rate in MHz.
	localparam int CLK_MHZ = 100;
	// Times in their own units.
	localparam int DOZE_WAKE_NS = 300;
	localparam int DEEP_WAKE_INT_MS = 500;
	localparam int DEEP_WAKE_EXT_US = 80;
	localparam int CONV_NS = 300;
	localparam int START_LOW_NS = 20;
	localparam int QUIET_NS = 20;
	localparam int STROBE_NS = 20;
	// Cycle counts, least times rounded up.
	localparam int DOZE_WAKE_CYC = (DOZE_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int DEEP_WAKE_EXT_CYC = DEEP_WAKE_EXT_US * CLK_MHZ;
	localparam int DEEP_WAKE_INT_CYC = DEEP_WAKE_INT_MS * 1000 * CLK_MHZ;
	localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int START_LOW_CYC = (START_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 32;
	// Data bus widths.
	localparam int DATA_W = 13;
	localparam int OFS_W = 10;
	localparam logic signed [15:0] OFS_MIN = -16'sd327;
	localparam logic signed [15:0] OFS_MAX = 16'sd327;
	// Own register map, byte addresses over Avalon-MM.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_OFFSET = 4'h8;
	localparam logic [3:0] REG_RESULT = 4'hC;
	// Control fields.
	localparam int CTRL_START = 0;
	localparam int CTRL_WRITE_OFS = 1;
	localparam int CTRL_DOZE = 2;
	localparam int CTRL_DEEP = 3;
	localparam int CTRL_EXT_REF = 4;
	localparam int CTRL_REF_KEPT = 5;
	localparam int CTRL_SATURATE = 6;
	localparam int CTRL_DELAYED = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
	// Status fields.
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_RESULT_NEW = 2;
	localparam int ST_OFS_BAD = 3;
	localparam int ST_DOZE_BAD = 4;

	typedef enum logic [2:0] {
		SARH_IDLE = 3'b000,
		SARH_START = 3'b001,
		SARH_CONV = 3'b011,
		SARH_QUIET = 3'b010,
		SARH_READ = 3'b110,
		SARH_WRITE = 3'b111
	} sarh_state_e;

	// Pins toward the converter.
	typedef struct packed {
		logic sample_start_n;
		logic chip_sel_n;
		logic rd_n;
		logic wr_n;
		logic doze_pin;
		logic deep_sleep_pin;
		logic saturate_enable;
		logic mode1;
		logic mode2;
	} sarh_pins_s;
endpackage : sarh_pkg

// file: sarh_timer.sv
`timescale 1ns/1ps
module sarh_timer (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [31:0] count,
	output logic done
);
	logic [31:0] left;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			left <= 32'h0000_0000;
		end else if (load) begin
			left <= count;
		end else if (left != 32'h0000_0000) begin
			left <= left - 32'h0000_0001;
		end
	end

	assign done = (left == 32'h0000_0000) && !load;
endmodule : sarh_timer

// file: sarh_ofs_check.sv
`timescale 1ns/1ps
module sarh_ofs_check (
	input wire logic [15:0] value,
	output logic ok,
	output logic [12:0] word
);
	wire logic signed [15:0] sval = value;
	assign ok = (sval >= sarh_pkg::OFS_MIN) && (sval <= sarh_pkg::OFS_MAX);
	// Upper three bits stay zero, value in two's complement below.
	assign word = {3'b000, value[9:0]};
endmodule : sarh_ofs_check

// file: sarh_host.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
// How it works
// RULE_01: Drive doze or deep-sleep pin high to select power-down mode.
// RULE_02: Device finishes conversion in fixed time; host waits for busy high.
// RULE_03: After doze release with external reference, wait settling time.
// RULE_04: Never use doze mode while on-chip reference is selected.
// RULE_05: After deep sleep with on-chip reference wait long power-up time.
// RULE_06: With external reference kept powered, deep-sleep wait is shorter.
// RULE_07: Saturate high and zero offset gives plain 12-bit results.
// RULE_08: Top data bit flags overrange in saturating operation.
// RULE_09: Device adds stored offset to each raw result.
// RULE_10: Saturate high clamps results between zero and all ones.
// RULE_11: Saturate low leaves result unclamped across thirteen bits.
// RULE_12: Only offsets within the signed permitted range are written.
// RULE_13: Offset goes out as ten value bits with upper three zero.
// RULE_14: Mode pins drive 0/1 or 1/0, never equal values.
// RULE_15: Immediate mode result is read after busy rises.
// RULE_16: Delayed mode result belongs to the previous conversion.
// RULE_17: Never read data while a conversion is in progress.
// RULE_18: Fast continuous use needs strobes tied low and buffered data.
// RULE_19: Input multiplexer switching belongs right after busy falls.
// RULE_20: Device pulls busy low at start and raises it at end.
// RULE_21: Device drives data only while chip select and read are low.
// RULE_22: Offset is a two's complement signed value.
// RULE_23: Device keeps offset until reset; rewrite between conversions.
// RULE_24: Device clears offset on reset and adds without wraparound.
// RULE_25: Device ignores start requests while in either power-down mode.
module sarh_host #(
	parameter int DEEP_WAKE_INT_CYC = sarh_pkg::DEEP_WAKE_INT_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output sarh_pkg::sarh_pins_s pins,
	input wire logic busy_n,
	input wire logic [12:0] data_in,
	output logic [12:0] data_out,
	output logic data_oe,
	output logic mux_switch
);
	// ******************************************************************
	// Register bus
	// ******************************************************************
	logic [31:0] ctrl;
	logic [15:0] ofs_value;
	logic [12:0] result;
	logic result_new;
	logic ofs_bad;
	logic doze_bad;
	logic rd_ack;
	sarh_pkg::sarh_state_e state;
	sarh_pkg::sarh_state_e next_state;
	wire logic [12:0] ofs_word;
	wire logic ofs_ok;
	wire logic wake_done;
	wire logic phase_done;
	wire logic sel_ctrl = avs_address == sarh_pkg::REG_CTRL;
	wire logic sel_status = avs_address == sarh_pkg::REG_STATUS;
	wire logic sel_offset = avs_address == sarh_pkg::REG_OFFSET;
	wire logic sel_result = avs_address == sarh_pkg::REG_RESULT;
	wire logic wr_ctrl = avs_write && sel_ctrl && avs_byteenable[0];
	wire logic wr_ofs = avs_write && sel_offset;
	wire logic idle = state == sarh_pkg::SARH_IDLE;
	wire logic any_sleep = ctrl[sarh_pkg::CTRL_DOZE] || ctrl[sarh_pkg::CTRL_DEEP];
	wire logic ready = idle && wake_done && !any_sleep;
	wire logic start_req = wr_ctrl && avs_writedata[sarh_pkg::CTRL_START];
	wire logic ofs_req = wr_ctrl && avs_writedata[sarh_pkg::CTRL_WRITE_OFS];
	// A command that also asks for a power-down mode starts no transfer.
	wire logic stay_awake = !avs_writedata[sarh_pkg::CTRL_DOZE] && !avs_writedata[sarh_pkg::CTRL_DEEP];
	// Start and offset-write commands wait until the converter is idle and awake.
	wire logic cmd_req = start_req || ofs_req;
	wire logic [31:0] status_word = {27'h0, doze_bad, ofs_bad, result_new, ready, !idle};

	always_comb begin
		avs_waitrequest = 1'b0;
		if (cmd_req && !ready) begin
			avs_waitrequest = 1'b1;
		end
		if (avs_read && !rd_ack) begin
			avs_waitrequest = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_ack <= avs_read && !rd_ack;
			if (avs_read && !rd_ack) begin
				avs_readdata <= sel_ctrl ? ctrl :
					sel_status ? status_word :
					sel_offset ? {16'h0000, ofs_value} :
					sel_result ? {19'h0, result} : 32'h0000_0000;
			end
		end
	end

	// ******************************************************************
	// Control register
	// ******************************************************************
	// RULE_04 doze refused with on-chip reference
	wire logic doze_req = avs_writedata[sarh_pkg::CTRL_DOZE] && avs_writedata[sarh_pkg::CTRL_EXT_REF];
	wire logic doze_refused = avs_writedata[sarh_pkg::CTRL_DOZE] && !avs_writedata[sarh_pkg::CTRL_EXT_REF];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= sarh_pkg::CTRL_RESET;
			ofs_value <= 16'h0000;
			doze_bad <= 1'b0;
		end else begin
			if (wr_ctrl && !(cmd_req && !ready)) begin
				ctrl <= {24'h0, avs_writedata[7:3], doze_req, 2'b00};
				doze_bad <= doze_refused;
			end
			// RULE_12 offset stored as written; range checked before any write transfer
			if (wr_ofs) begin
				ofs_value <= avs_writedata[15:0];
			end
		end
	end

	wire logic [15:0] new_ofs = avs_writedata[15:0];
	wire logic signed [15:0] new_ofs_s = new_ofs;
	wire logic ofs_ok_new = (new_ofs_s >= sarh_pkg::OFS_MIN) && (new_ofs_s <= sarh_pkg::OFS_MAX);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ofs_bad <= 1'b0;
		end else if (wr_ofs) begin
			ofs_bad <= !ofs_ok_new;
		end
	end

	sarh_ofs_check u_ofs (
		.value(ofs_value),
		.ok(ofs_ok),
		.word(ofs_word)
	);

	// ******************************************************************
	// Power-down pins and wake waits
	// ******************************************************************
	logic doze_q;
	logic deep_q;
	wire logic wake_load = (doze_q && !ctrl[sarh_pkg::CTRL_DOZE]) ||
		(deep_q && !ctrl[sarh_pkg::CTRL_DEEP]);
	// RULE_03 RULE_05 RULE_06 wake wait select
	wire logic [31:0] wake_count = doze_q ? 32'(sarh_pkg::DOZE_WAKE_CYC) :
		ctrl[sarh_pkg::CTRL_EXT_REF] && ctrl[sarh_pkg::CTRL_REF_KEPT] ?
		32'(sarh_pkg::DEEP_WAKE_EXT_CYC) : 32'(DEEP_WAKE_INT_CYC);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			doze_q <= 1'b0;
			deep_q <= 1'b0;
		end else begin
			doze_q <= ctrl[sarh_pkg::CTRL_DOZE];
			deep_q <= ctrl[sarh_pkg::CTRL_DEEP];
		end
	end

	sarh_timer u_wake (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.load(wake_load),
		.count(wake_count),
		.done(wake_done)
	);

	// ******************************************************************
	// Conversion and transfer sequencer
	// ******************************************************************
	logic is_write;
	logic busy_seen_low;
	logic phase_load;
	logic [31:0] phase_count;

	sarh_timer u_phase (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.load(phase_load),
		.count(phase_count),
		.done(phase_done)
	);

	always_comb begin
		next_state = state;
		phase_load = 1'b0;
		phase_count = 32'h0000_0000;
		unique case (state)
			sarh_pkg::SARH_IDLE: begin
				if (start_req && ready && stay_awake) begin
					next_state = sarh_pkg::SARH_START;
					phase_load = 1'b1;
					phase_count = 32'(sarh_pkg::START_LOW_CYC);
				end else if (ofs_req && ready && ofs_ok && stay_awake) begin
					next_state = sarh_pkg::SARH_WRITE;
					phase_load = 1'b1;
					phase_count = 32'(sarh_pkg::STROBE_CYC);
				end
			end
			sarh_pkg::SARH_START: begin
				if (phase_done) begin
					next_state = sarh_pkg::SARH_CONV;
				end
			end
			// RULE_02 RULE_20 wait for busy rise
			sarh_pkg::SARH_CONV: begin
				if (busy_seen_low && busy_n) begin
					next_state = sarh_pkg::SARH_QUIET;
				end
			end
			// RULE_17 read only after conversion end
			sarh_pkg::SARH_QUIET: begin
				next_state = sarh_pkg::SARH_READ;
				phase_load = 1'b1;
				phase_count = 32'(sarh_pkg::STROBE_CYC);
			end
			// RULE_18 one full read per conversion
			sarh_pkg::SARH_READ: begin
				if (phase_done) begin
					next_state = sarh_pkg::SARH_IDLE;
				end
			end
			sarh_pkg::SARH_WRITE: begin
				if (phase_done) begin
					next_state = sarh_pkg::SARH_IDLE;
				end
			end
			default: begin
				next_state = sarh_pkg::SARH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= sarh_pkg::SARH_IDLE;
			busy_seen_low <= 1'b0;
			is_write <= 1'b0;
		end else begin
			state <= next_state;
			is_write <= next_state == sarh_pkg::SARH_WRITE;
			if (state != sarh_pkg::SARH_CONV) begin
				busy_seen_low <= 1'b0;
			end else if (!busy_n) begin
				busy_seen_low <= 1'b1;
			end
		end
	end

	// ******************************************************************
	// Pins and result capture
	// ******************************************************************
	wire logic in_read = state == sarh_pkg::SARH_READ;
	wire logic in_write = state == sarh_pkg::SARH_WRITE;
	wire logic read_end = in_read && phase_done;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			result <= 13'h0000;
			result_new <= 1'b0;
			data_out <= 13'h0000;
			mux_switch <= 1'b0;
		end else begin
			// RULE_15 RULE_16 result capture after conversion
			if (read_end) begin
				result <= data_in;
			end
			// Capture wins over clear by a result read.
			if (read_end) begin
				result_new <= 1'b1;
			end else if (avs_read && sel_result && rd_ack) begin
				result_new <= 1'b0;
			end
			// RULE_13 RULE_22 offset word format
			data_out <= ofs_word;
			// RULE_19 multiplexer cue after busy falls
			mux_switch <= state == sarh_pkg::SARH_CONV && !busy_n && !busy_seen_low;
		end
	end

	// RULE_21 read strobe low only during the read; chip select also during the write
	// RULE_14 mode pins never equal
	always_comb begin
		pins.sample_start_n = state != sarh_pkg::SARH_START;
		pins.chip_sel_n = !(in_read || in_write);
		pins.rd_n = !in_read;
		pins.wr_n = !in_write;
		// RULE_01 power-down pins from control
		pins.doze_pin = ctrl[sarh_pkg::CTRL_DOZE];
		pins.deep_sleep_pin = ctrl[sarh_pkg::CTRL_DEEP];
		// RULE_07 RULE_08 RULE_10 RULE_11 saturation select
		pins.saturate_enable = ctrl[sarh_pkg::CTRL_SATURATE];
		pins.mode1 = !ctrl[sarh_pkg::CTRL_DELAYED];
		pins.mode2 = ctrl[sarh_pkg::CTRL_DELAYED];
	end
	assign data_oe = in_write && is_write;

	// ******************************************************************
	// Checks
	// ******************************************************************
	a_mode_pins_differ: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_14
		pins.mode1 != pins.mode2) else $error("mode pins equal");
	a_no_read_busy: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_17
		!pins.rd_n |-> busy_n) else $error("read during conversion");
	a_no_doze_int: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_04
		pins.doze_pin |-> ctrl[sarh_pkg::CTRL_EXT_REF]) else $error("doze with internal ref");
	a_no_start_sleep: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_25
		!pins.sample_start_n |-> !pins.doze_pin && !pins.deep_sleep_pin)
		else $error("start while asleep");
	a_doze_wait: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_03
		$fell(pins.doze_pin) |-> pins.sample_start_n [*8]) else $error("start too soon after doze");
	a_ofs_upper_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_13
		data_oe |-> data_out[12:10] == 3'b000) else $error("offset upper bits set");
	a_ofs_in_range: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_12
		$rose(data_oe) |-> ofs_ok) else $error("offset out of range");
	a_result_capture: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_15
		read_end |=> result == $past(data_in) && result_new) else $error("result not taken");
	a_start_to_conv: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_20
		$rose(state == sarh_pkg::SARH_START) |-> ##[1:4] state == sarh_pkg::SARH_CONV)
		else $error("start pulse too long");
	// Strobe shapes and wake gaps as the converter sees them, and the multiplexer cue.
	a_read_pair: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_21
		!pins.rd_n |-> !pins.chip_sel_n && pins.wr_n)
		else $error("read strobe without chip select");
	a_write_drives: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_22
		!pins.wr_n |-> data_oe && !pins.chip_sel_n)
		else $error("write strobe without data drive");
	a_mux_one_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_19
		mux_switch |=> !mux_switch)
		else $error("multiplexer cue longer than one cycle");
	a_deep_wait: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_05
		$fell(pins.deep_sleep_pin) |-> pins.sample_start_n [*8])
		else $error("start too soon after deep sleep");
	a_read_after_busy: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE_17
		$fell(pins.rd_n) |-> busy_n && $past(busy_n))
		else $error("read begins while busy");
endmodule : sarh_host

// file: sarh_adc_model.sv
`timescale 1ns/1ps
module sarh_adc_model #(
	parameter int DEEP_INT_CYC = 100
) (
	input wire logic sys_clk,
	input wire sarh_pkg::sarh_pins_s pins,
	input wire logic ext_ref,
	input wire logic ref_kept,
	input wire logic signed [13:0] analog,
	input wire logic [12:0] bus_in,
	output logic busy_n = 1'b1,
	output logic [12:0] dev_q,
	output logic fault = 1'b0
);
	logic signed [9:0] offset = '0;
	logic [12:0] out_reg = '0;
	logic [12:0] pending = '0;
	logic [12:0] last_q = '0;
	logic prev_start = 1'b1;
	int conv_cnt = 0;
	int wake_cnt = 0;
	int wake_need = 0;
	logic signed [15:0] sum;
	logic [12:0] code;
	logic drive;
	logic asleep;
	assign sum = {{2{analog[13]}}, analog} + {{6{offset[9]}}, offset};
	assign code = !pins.saturate_enable ? sum[12:0] : (sum < 16'sh0000) ? 13'h1000 :
		(sum > 16'sh0FFF) ? 13'h1FFF : {1'b0, sum[11:0]};
	assign drive = !pins.chip_sel_n && !pins.rd_n;
	assign dev_q = drive ? out_reg : ~last_q;
	assign asleep = pins.doze_pin || pins.deep_sleep_pin;
	always @(posedge sys_clk) begin
		prev_start <= pins.sample_start_n;
		if (drive) last_q <= out_reg;
		if (asleep) begin
			wake_cnt <= 0;
			wake_need <= pins.doze_pin ? sarh_pkg::DOZE_WAKE_CYC :
				(ext_ref && ref_kept) ? sarh_pkg::DEEP_WAKE_EXT_CYC : DEEP_INT_CYC;
			if (pins.doze_pin && !ext_ref) fault <= 1'b1;
		end else if (wake_cnt < wake_need) wake_cnt <= wake_cnt + 1;
		if (prev_start && !pins.sample_start_n && !asleep) begin
			if (wake_cnt < wake_need || pins.mode1 == pins.mode2) fault <= 1'b1;
			busy_n <= 1'b0;
			conv_cnt <= sarh_pkg::CONV_CYC;
			if (pins.mode2) out_reg <= pending;
		end
		if (!busy_n) begin
			if (conv_cnt > 1) conv_cnt <= conv_cnt - 1;
			else begin
				busy_n <= 1'b1;
				pending <= code;
				if (pins.mode1) out_reg <= code;
			end
		end
		if (!busy_n && drive) fault <= 1'b1;
		if (!pins.wr_n && !pins.chip_sel_n) begin
			offset <= bus_in[9:0];
			if (bus_in[12:10] != 3'h0) fault <= 1'b1;
		end
	end
endmodule : sarh_adc_model

// file: tb_sar_adc_host_port_offset_power.sv
`timescale 1ns/1ps
module tb_sar_adc_host_port_offset_power;
	typedef struct packed {
		logic sat;
		logic dly;
		logic [15:0] ofs;
		logic [13:0] ain;
		logic [12:0] res;
	} sarh_row_s;
	localparam sarh_row_s ROWS [12] = '{
		'{1'h1, 1'h0, 16'hFF80, 14'h0FFF, 13'h0F7F}, '{1'h1, 1'h0, 16'h0100, 14'h0000, 13'h0100},
		'{1'h1, 1'h0, 16'h0100, 14'h0FFF, 13'h1FFF}, '{1'h1, 1'h0, 16'hFF80, 14'h0000, 13'h1000},
		'{1'h0, 1'h0, 16'h0100, 14'h3EB8, 13'h1FB8}, '{1'h0, 1'h0, 16'h0100, 14'h0FFF, 13'h10FF},
		'{1'h0, 1'h0, 16'h0100, 14'h1248, 13'h1348}, '{1'h1, 1'h0, 16'h0147, 14'h0064, 13'h01AB},
		'{1'h0, 1'h0, 16'hFEB9, 14'h01F4, 13'h00AD}, '{1'h1, 1'h0, 16'h0000, 14'h3FFB, 13'h1000},
		'{1'h1, 1'h1, 16'h0000, 14'h00DE, 13'h1000}, '{1'h1, 1'h1, 16'h0000, 14'h014D, 13'h00DE}};
	localparam logic [31:0] START = 32'h1;
	localparam logic [31:0] WR_OFS = 32'h2;
	localparam logic [31:0] DOZE = 32'h4;
	localparam logic [31:0] DEEP = 32'h8;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	sarh_pkg::sarh_pins_s pins;
	logic busy_n;
	logic [12:0] data_out;
	logic data_oe;
	logic mux_switch;
	logic [12:0] dev_q;
	logic [12:0] bus;
	logic fault;
	logic signed [13:0] analog = 14'h0000;
	logic [31:0] ctrl = sarh_pkg::CTRL_RESET;
	logic [31:0] rd;
	int n_mismatch = 0;
	int check_count = 0;
	int n_conv = 0;
	int n_mux = 0;
	int cycles = 0;
	assign bus = data_oe ? data_out : dev_q;
	sarh_host #(.DEEP_WAKE_INT_CYC(100)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pins(pins), .busy_n(busy_n), .data_in(bus),
		.data_out(data_out), .data_oe(data_oe), .mux_switch(mux_switch));
	sarh_adc_model #(.DEEP_INT_CYC(100)) adc_u (.sys_clk(sys_clk), .pins(pins),
		.ext_ref(ctrl[sarh_pkg::CTRL_EXT_REF]), .ref_kept(ctrl[sarh_pkg::CTRL_REF_KEPT]),
		.analog(analog), .bus_in(bus), .busy_n(busy_n), .dev_q(dev_q), .fault(fault));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (mux_switch === 1'b1) n_mux <= n_mux + 1;
		if (cycles == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk_reg(input string name, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, e, s);
		end
	endtask : chk_reg
	task automatic bus_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic w;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Wait request is looked at while settled, and holds until the next rising edge.
		do begin
			@(negedge sys_clk);
			w = avs_waitrequest;
			@(posedge sys_clk);
		end while (w !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus_cycle
	task automatic write_ofs(input logic [15:0] v);
		bus_cycle(1'b1, sarh_pkg::REG_OFFSET, {16'h0000, v});
		bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl | WR_OFS);
	endtask : write_ofs
	task automatic convert();
		bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl | START);
		rd = 32'h0;
		for (int k = 0; k < 300 && rd[sarh_pkg::ST_RESULT_NEW] !== 1'b1; k++) begin
			bus_cycle(1'b0, sarh_pkg::REG_STATUS, 32'h0);
		end
		bus_cycle(1'b0, sarh_pkg::REG_RESULT, 32'h0);
		n_conv++;
	endtask : convert
	task automatic end_of_test();
		if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk_reg("mode_pins", 32'h1, {30'h0, pins.mode2, pins.mode1});
		bus_cycle(1'b0, sarh_pkg::REG_CTRL, 32'h0);
		chk_reg("ctrl_reset", sarh_pkg::CTRL_RESET, rd);
		bus_cycle(1'b0, 4'h2, 32'h0);
		chk_reg("unmapped", 32'h0, rd);
		foreach (ROWS[i]) begin
			ctrl = sarh_pkg::CTRL_RESET | {24'h0, ROWS[i].dly, ROWS[i].sat, 6'h00};
			write_ofs(ROWS[i].ofs);
			analog <= ROWS[i].ain;
			convert();
			chk_reg("result", {19'h0, ROWS[i].res}, {19'h0, rd[12:0]});
		end
		ctrl = 32'h40;
		bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl | DOZE);
		bus_cycle(1'b0, sarh_pkg::REG_STATUS, 32'h0);
		chk_reg("doze_refused", 32'h1, {30'h0, pins.doze_pin, rd[sarh_pkg::ST_DOZE_BAD]});
		write_ofs(16'h0148);
		bus_cycle(1'b0, sarh_pkg::REG_STATUS, 32'h0);
		chk_reg("ofs_bad", 32'h1, {31'h0, rd[sarh_pkg::ST_OFS_BAD]});
		ctrl = 32'h50;
		bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl | DOZE);
		@(negedge sys_clk);
		chk_reg("doze_pin", 32'h1, {31'h0, pins.doze_pin});
		bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl);
		analog <= 14'h0064;
		convert();
		chk_reg("doze_wake", 32'h64, {19'h0, rd[12:0]});
		for (int m = 0; m < 2; m++) begin
			ctrl = m ? 32'h40 : 32'h70;
			bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl | DEEP);
			@(negedge sys_clk);
			chk_reg("deep_pin", 32'h1, {31'h0, pins.deep_sleep_pin});
			bus_cycle(1'b1, sarh_pkg::REG_CTRL, ctrl);
			analog <= 14'h0C80 + 14'(m);
			convert();
			chk_reg("deep_wake", 32'hC80 + 32'(m), {19'h0, rd[12:0]});
		end
		chk_reg("mux_pulses", 32'(n_conv), 32'(n_mux));
		chk_reg("device_fault", 32'h0, {31'h0, fault});
		// A reset in mid-run brings back the reset control word and a cleared offset.
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		bus_cycle(1'b0, sarh_pkg::REG_OFFSET, 32'h0);
		chk_reg("ofs_after_reset", 32'h0, rd);
		bus_cycle(1'b0, sarh_pkg::REG_CTRL, 32'h0);
		chk_reg("ctrl_after_reset", sarh_pkg::CTRL_RESET, rd);
		end_of_test();
	end
endmodule : tb_sar_adc_host_port_offset_power
